// ===== pkg/alr_pkg.sv
package alr_pkg;
   // -------------------------------------------------------------
   // timing
   // -------------------------------------------------------------
   localparam int CLK_MHZ = 100; // system clock rate in MHz
   localparam int FRAME_MS = 100; // fixed frame in standard mode, ms
   localparam int MEAS_US = 300; // one single measurement, us
   localparam int FRAME_CYC = FRAME_MS * 1000 * CLK_MHZ;
   localparam int MEAS_CYC = MEAS_US * CLK_MHZ;

   // -------------------------------------------------------------
   // bus address and register map
   // -------------------------------------------------------------
   localparam logic [6:0] BUS_ADDR7 = 7'h13; // 26h write, 27h read
   localparam logic [7:0] REG_CFG = 8'h84; // ambient configuration
   localparam logic [7:0] REG_RES_HI = 8'h85; // result high byte
   localparam logic [7:0] REG_RES_LO = 8'h86; // result low byte
   localparam logic [7:0] CFG_RST = 8'h00; // configuration after reset
   localparam int CFG_CONT_BIT = 7; // 1 = back-to-back conversions
   localparam int CFG_AVG_MSB = 2; // averaging exponent, 2^n samples
   localparam logic [7:0] PTR_RST = 8'h00; // pointer after reset
   localparam logic [15:0] RES_RST = 16'h0000; // result after reset

   typedef enum logic [2:0] {
      I2_IDLE, I2_ADDR, I2_AACK, I2_WR, I2_WACK, I2_RD, I2_RACK
   } alr_i2c_st_t;

   typedef enum logic {CV_HOLD, CV_RUN} alr_conv_st_t;
endpackage

// ===== hw/alr_top.sv
`timescale 1ns/10ps
module alr_top #(
   parameter int FRAME_CYC = alr_pkg::FRAME_CYC, // frame length, cycles
   parameter int MEAS_CYC = alr_pkg::MEAS_CYC // measurement, cycles
) (
   input wire logic clk_sys_i, // 100 MHz system clock
   input wire logic arst_n_i, // async reset, active low
   input wire logic scl_i, // serial clock pin level
   input wire logic sda_i, // serial data pin level
   output logic sda_o, // serial data drive value, always low
   output logic sda_oe_o, // high while pulling data low
   input wire logic [15:0] amb_adc_i, // front-end sample, same clock
   output logic meas_active_o // high through each run of back-to-back measurements
);
   // -------------------------------------------------------------
   // pin synchronisers and bus conditions
   // -------------------------------------------------------------
   logic scl_s1, scl_s2, scl_q, sda_s1, sda_s2, sda_q;
   logic scl_rise, scl_fall, start_det, stop_det;
   // two flops per pin, third for edges; open-drain drive fixed low
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         {scl_s1, scl_s2, scl_q} <= 3'b111;
         {sda_s1, sda_s2, sda_q} <= 3'b111;
         sda_o <= 1'b0;
      end else begin
         {scl_s1, scl_s2, scl_q} <= {scl_i, scl_s1, scl_s2};
         {sda_s1, sda_s2, sda_q} <= {sda_i, sda_s1, sda_s2};
         sda_o <= 1'b0;
      end
   end

   // start and stop are data edges while the clock stays high
   assign scl_rise = scl_s2 && !scl_q;
   assign scl_fall = !scl_s2 && scl_q;
   assign start_det = scl_s2 && scl_q && sda_q && !sda_s2;
   assign stop_det = scl_s2 && scl_q && !sda_q && sda_s2;

   // -------------------------------------------------------------
   // register read decode
   // -------------------------------------------------------------
   logic [7:0] cfg, ptr, rd_byte;
   logic [15:0] result;
   function automatic logic [7:0] reg_rd(input logic [7:0] p, c,
                                         input logic [15:0] r);
      case (p)
         alr_pkg::REG_CFG: reg_rd = c;
         alr_pkg::REG_RES_HI: reg_rd = r[15:8];
         alr_pkg::REG_RES_LO: reg_rd = r[7:0];
         default: reg_rd = 8'h00;
      endcase
   endfunction
   assign rd_byte = reg_rd(ptr, cfg, result);

   // -------------------------------------------------------------
   // serial target state machine
   // -------------------------------------------------------------
   alr_pkg::alr_i2c_st_t st;
   logic [3:0] bit_cnt;
   logic [7:0] shreg;
   logic [6:0] tx;
   logic rd_mode, first, nack;
   // a start from any state restarts, so repeated start needs no stop
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st <= alr_pkg::I2_IDLE;
         bit_cnt <= 4'h0;
         shreg <= 8'h00;
         tx <= 7'h00;
         ptr <= alr_pkg::PTR_RST;
         cfg <= alr_pkg::CFG_RST;
         sda_oe_o <= 1'b0;
         {rd_mode, first, nack} <= 3'b000;
      end else if (start_det) begin
         st <= alr_pkg::I2_ADDR;
         bit_cnt <= 4'h0;
         sda_oe_o <= 1'b0;
      end else if (stop_det) begin
         st <= alr_pkg::I2_IDLE;
         sda_oe_o <= 1'b0;
      end else if (scl_rise) begin
         case (st)
            alr_pkg::I2_ADDR, alr_pkg::I2_WR: begin
               shreg <= {shreg[6:0], sda_s2};
               bit_cnt <= bit_cnt + 4'h1;
            end
            alr_pkg::I2_RACK: nack <= sda_s2;
            default: ;
         endcase
      end else if (scl_fall) begin
         case (st)
            alr_pkg::I2_ADDR: begin
               if (bit_cnt == 4'h8) begin
                  if (shreg[7:1] == alr_pkg::BUS_ADDR7) begin
                     st <= alr_pkg::I2_AACK;
                     sda_oe_o <= 1'b1;
                     rd_mode <= shreg[0];
                  end else begin
                     st <= alr_pkg::I2_IDLE;
                  end
               end
            end
            alr_pkg::I2_AACK: begin
               bit_cnt <= 4'h0;
               if (rd_mode) begin
                  tx <= rd_byte[6:0];
                  sda_oe_o <= ~rd_byte[7];
                  ptr <= ptr + 8'h01;
                  st <= alr_pkg::I2_RD;
               end else begin
                  sda_oe_o <= 1'b0;
                  first <= 1'b1;
                  st <= alr_pkg::I2_WR;
               end
            end
            alr_pkg::I2_WR: begin
               if (bit_cnt == 4'h8) begin
                  sda_oe_o <= 1'b1;
                  st <= alr_pkg::I2_WACK;
                  first <= 1'b0;
                  if (first) begin
                     ptr <= shreg; // pointer byte, no data needed
                  end else begin
                     if (ptr == alr_pkg::REG_CFG) cfg <= shreg;
                     ptr <= ptr + 8'h01;
                  end
               end
            end
            alr_pkg::I2_WACK: begin
               sda_oe_o <= 1'b0;
               bit_cnt <= 4'h0;
               st <= alr_pkg::I2_WR;
            end
            alr_pkg::I2_RD: begin
               bit_cnt <= bit_cnt + 4'h1;
               if (bit_cnt == 4'h7) begin
                  sda_oe_o <= 1'b0; // release for host ack
                  st <= alr_pkg::I2_RACK;
               end else begin
                  tx <= {tx[5:0], 1'b1};
                  sda_oe_o <= ~tx[6];
               end
            end
            alr_pkg::I2_RACK: begin
               if (!nack) begin
                  tx <= rd_byte[6:0];
                  sda_oe_o <= ~rd_byte[7];
                  ptr <= ptr + 8'h01;
                  bit_cnt <= 4'h0;
                  st <= alr_pkg::I2_RD;
               end else begin
                  st <= alr_pkg::I2_IDLE;
               end
            end
            default: st <= alr_pkg::I2_IDLE;
         endcase
      end
   end

   // -------------------------------------------------------------
   // conversion sequencer
   // -------------------------------------------------------------
   alr_pkg::alr_conv_st_t cv_st;
   logic [23:0] frame_cnt;
   logic [23:0] meas_tmr;
   logic [7:0] done_cnt, avg_n;
   logic [22:0] acc, next_sum;
   logic [15:0] avg_val;
   logic cont, frame_end, meas_end, pub;

   assign cont = cfg[alr_pkg::CFG_CONT_BIT];
   assign avg_n = 8'h01 << cfg[alr_pkg::CFG_AVG_MSB:0];
   assign frame_end = frame_cnt == 24'(FRAME_CYC - 1);
   assign meas_end = meas_active_o && meas_tmr == 24'(MEAS_CYC - 1);
   // running sum and its average; a shift is exact for 2^n samples
   always_comb begin
      next_sum = acc + {7'h00, amb_adc_i};
      avg_val = 16'(acc >> cfg[alr_pkg::CFG_AVG_MSB:0]);
   end
   // frame timebase runs free so frame edges stay evenly spaced
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         frame_cnt <= 24'h000000;
      end else if (frame_end) begin
         frame_cnt <= 24'h000000;
      end else begin
         frame_cnt <= frame_cnt + 24'h000001;
      end
   end
   // measurements, averaging and publication of the result
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cv_st <= alr_pkg::CV_HOLD;
         meas_tmr <= 24'h000000;
         meas_active_o <= 1'b0;
         done_cnt <= 8'h00;
         acc <= 23'h000000;
         result <= alr_pkg::RES_RST;
         pub <= 1'b0;
      end else begin
         pub <= 1'b0;
         case (cv_st)
            alr_pkg::CV_HOLD: begin
               if (cont || frame_end) begin
                  if (!cont && done_cnt == avg_n) begin
                     result <= avg_val;
                     pub <= 1'b1;
                  end
                  acc <= 23'h000000;
                  done_cnt <= 8'h00;
                  meas_tmr <= 24'h000000;
                  meas_active_o <= 1'b1;
                  cv_st <= alr_pkg::CV_RUN;
               end
            end
            alr_pkg::CV_RUN: begin
               if (!meas_end) begin
                  meas_tmr <= meas_tmr + 24'h000001;
               end else begin
                  meas_tmr <= 24'h000000;
                  if (done_cnt + 8'h01 != avg_n) begin
                     acc <= next_sum;
                     done_cnt <= done_cnt + 8'h01;
                  end else if (cont) begin
                     result <= 16'(next_sum >>
                                   cfg[alr_pkg::CFG_AVG_MSB:0]);
                     pub <= 1'b1;
                     acc <= 23'h000000;
                     done_cnt <= 8'h00;
                  end else begin
                     acc <= next_sum;
                     done_cnt <= avg_n;
                     meas_active_o <= 1'b0;
                     cv_st <= alr_pkg::CV_HOLD;
                  end
               end
            end
            default: cv_st <= alr_pkg::CV_HOLD;
         endcase
      end
   end

   // -------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------
   repstart_fsm_a: assert property (@(posedge clk_sys_i)
      disable iff (!arst_n_i) start_det |=> st == alr_pkg::I2_ADDR)
      else $error("start did not enter address phase");
   frame_wrap_a: assert property (@(posedge clk_sys_i)
      disable iff (!arst_n_i) frame_end |=> frame_cnt == 24'h000000)
      else $error("frame counter did not wrap");
   std_publish_a: assert property (@(posedge clk_sys_i)
      disable iff (!arst_n_i) pub && !$past(cont) |-> $past(frame_end))
      else $error("standard result published off frame end");
   cont_publish_a: assert property (@(posedge clk_sys_i)
      disable iff (!arst_n_i)
      pub && $past(cont) |-> $past(done_cnt) + 8'h01 == $past(avg_n))
      else $error("continuous result published early");
   meas_length_a: assert property (@(posedge clk_sys_i)
      disable iff (!arst_n_i) $rose(meas_active_o) |-> meas_active_o[*8])
      else $error("measurement ended too early");
   back_to_back_a: assert property (@(posedge clk_sys_i)
      disable iff (!arst_n_i) meas_end && cont |=> meas_active_o
         && meas_tmr == 24'h000000)
      else $error("continuous measurement not restarted");
   avg_value_a: assert property (@(posedge clk_sys_i)
      disable iff (!arst_n_i) pub && !$past(cont) |->
         result == $past(avg_val))
      else $error("published result is not the average");
   ptr_advance_a: assert property (@(posedge clk_sys_i)
      disable iff (!arst_n_i)
      scl_fall && !start_det && !stop_det && st == alr_pkg::I2_RACK
         && !nack |=> ptr == $past(ptr) + 8'h01)
      else $error("pointer did not advance after read byte");
   hi_byte_a: assert property (@(posedge clk_sys_i)
      disable iff (!arst_n_i)
      scl_fall && !start_det && !stop_det && st == alr_pkg::I2_AACK
         && rd_mode && ptr == alr_pkg::REG_RES_HI
         |=> {~sda_oe_o, tx} == $past(result[15:8]))
      else $error("high result byte not loaded");
   lo_byte_a: assert property (@(posedge clk_sys_i)
      disable iff (!arst_n_i)
      scl_fall && !start_det && !stop_det && st == alr_pkg::I2_RACK
         && !nack && ptr == alr_pkg::REG_RES_LO
         |=> {~sda_oe_o, tx} == $past(result[7:0]))
      else $error("low result byte not loaded");
endmodule

// ===== testbench/alr_host_model.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// serial bus host model
// ---------------------------------------------------------------
module alr_host_model (
   input wire logic clk_sys_i, // paces the bit phases
   input wire logic dev_oe_i, // device pulls data low
   output logic scl_o, // serial clock, stands high when idle
   output logic sda_oe_o, // host pulls data low
   output logic sda_w_o // resolved data wire level
);
   // open-drain wire with pull-up: a released line reads high
   assign sda_w_o = !(sda_oe_o | dev_oe_i);
   initial begin
      scl_o = 1'b1;
      sda_oe_o = 1'b0;
   end
   // 5 clocks a phase keeps both phases above the 4-clock minimum
   task automatic hp();
      repeat (5) @(negedge clk_sys_i);
   endtask
   // start or repeated start: data falls while the clock is high
   task automatic start();
      sda_oe_o = 1'b0;
      hp();
      scl_o = 1'b1;
      hp();
      sda_oe_o = 1'b1;
      hp();
      scl_o = 1'b0;
      hp();
   endtask
   // stop: data rises while the clock is high
   task automatic stop();
      sda_oe_o = 1'b1;
      hp();
      scl_o = 1'b1;
      hp();
      sda_oe_o = 1'b0;
      hp();
   endtask
   // one bit out, one bit in; sampled late so the device has settled
   task automatic bit_io(input logic b, output logic r);
      sda_oe_o = !b;
      hp();
      scl_o = 1'b1;
      hp();
      r = sda_w_o;
      scl_o = 1'b0;
      hp();
   endtask
   // byte out msb first, returns the ack bit (low = taken)
   task automatic wbyte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         bit_io(b[i], ack);
      end
      bit_io(1'b1, ack);
   endtask
   // byte in msb first, then ack, or nack on the last byte
   task automatic rbyte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, d[i]);
      end
      bit_io(last, r);
   endtask
endmodule

// ===== testbench/tb_alr_top.sv
`timescale 1ns/10ps
`define CHK(got, exp) begin \
   compares++; \
   if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("wrong value at %0t ns: got %0h expected %0h", \
         $time, (got), (exp)); \
   end \
end
module tb_alr_top;
   localparam int MEAS = 10;
   localparam int FRAME = 2000;
   logic clk_sys_i;
   logic arst_n_i;
   logic [15:0] amb_adc_i;
   logic scl, sda_w, dev_oe, dev_sda, meas_act;
   int error_cnt = 0;
   int compares = 0;
   int cyc = 0;
   // ---------------------------------------------------------------
   // design and host
   // ---------------------------------------------------------------
   alr_top #(.FRAME_CYC(FRAME), .MEAS_CYC(MEAS)) i_alr_top (
      .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .scl_i(scl),
      .sda_i(sda_w), .sda_o(dev_sda), .sda_oe_o(dev_oe),
      .amb_adc_i(amb_adc_i), .meas_active_o(meas_act));
   alr_host_model i_alr_host_model (.clk_sys_i(clk_sys_i),
      .dev_oe_i(dev_oe), .scl_o(scl), .sda_oe_o(), .sda_w_o(sda_w));
   // ---------------------------------------------------------------
   // clock, timeout and verdict
   // ---------------------------------------------------------------
   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   // the sequence needs about 11k cycles; a hang stops at 40k
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 40000) begin
         error_cnt++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      $display("compares %0d, mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // register access over the serial bus
   // ---------------------------------------------------------------
   task automatic set_ptr(input logic [7:0] p, input logic sr);
      logic a;
      i_alr_host_model.start();
      i_alr_host_model.wbyte(8'h26, a);
      `CHK(a, 1'b0)
      i_alr_host_model.wbyte(p, a);
      `CHK(a, 1'b0)
      if (!sr) i_alr_host_model.stop();
   endtask
   task automatic wr_reg(input logic [7:0] p, input logic [7:0] d);
      logic a;
      set_ptr(p, 1'b1);
      i_alr_host_model.wbyte(d, a);
      `CHK(a, 1'b0)
      i_alr_host_model.stop();
   endtask
   // no snapshot in the design, so callers hold the sample steady
   task automatic rd_res(input logic sr, input logic [15:0] e);
      logic a;
      logic [7:0] hi, lo, nx;
      set_ptr(8'h85, sr);
      i_alr_host_model.start();
      i_alr_host_model.wbyte(8'h27, a);
      `CHK(a, 1'b0)
      i_alr_host_model.rbyte(1'b0, hi);
      i_alr_host_model.rbyte(1'b0, lo);
      i_alr_host_model.rbyte(1'b1, nx);
      i_alr_host_model.stop();
      `CHK(hi, e[15:8])
      `CHK(lo, e[7:0])
      `CHK(nx, 8'h00)
      `CHK(dev_sda, 1'b0)
   endtask
   // waits for a run, notes its start, counts high cycles up to cap
   task automatic run_len(input int cap, output int len, output int t);
      int k;
      k = 0;
      len = 0;
      while (meas_act !== 1'b1 && k < 5000) begin
         @(negedge clk_sys_i);
         k++;
      end
      t = cyc;
      while (meas_act === 1'b1 && len < cap) begin
         @(negedge clk_sys_i);
         len++;
      end
   endtask
   // ---------------------------------------------------------------
   // test sequence
   // ---------------------------------------------------------------
   initial begin
      int n, t1, t2;
      logic a;
      arst_n_i = 1'b0;
      amb_adc_i = 16'h1234;
      repeat (8) @(negedge clk_sys_i);
      arst_n_i = 1'b1;
      repeat (3) @(negedge clk_sys_i);
      rd_res(1'b0, 16'h0000);
      wr_reg(8'h84, 8'h03);
      $display("test reset readout done");
      run_len(5000, n, t1);
      `CHK(n, 8 * MEAS)
      rd_res(1'b0, 16'h0000);
      run_len(5000, n, t2);
      `CHK(t2 - t1, FRAME)
      rd_res(1'b1, 16'h1234);
      $display("test fixed frame done");
      amb_adc_i = 16'h00F0;
      wr_reg(8'h84, 8'h81);
      run_len(300, n, t1);
      `CHK(n, 300)
      rd_res(1'b1, 16'h00F0);
      $display("test back-to-back done");
      amb_adc_i = 16'hABCD;
      wr_reg(8'h84, 8'h87);
      // two full groups of 128 so no mixed group is left
      repeat (2700) @(negedge clk_sys_i);
      wr_reg(8'h85, 8'hFF); // read-only place, data dropped
      rd_res(1'b1, 16'hABCD);
      i_alr_host_model.start();
      i_alr_host_model.wbyte(8'h28, a);
      `CHK(a, 1'b1)
      i_alr_host_model.stop();
      $display("test averaging and refusals done");
      wrap_up();
   end
endmodule
